/* sfr_flash_read.sv */
// serial flash front end: page read, buffer reads, transfer, compare
// assumes i_sck is the host's spi clock and i_cs_n its chip select pin;
// the array is filled over the load port, standing in for program paths
`timescale 1ns/1ns
`default_nettype none

// Summary of operation
// - link works in spi mode 0 or 3: sample on rise, drive on fall
// - instruction opens at chip select fall with 8-bit opcode, address
// - each serial clock while selected shifts one input bit in
// - everything moves most significant bit first
// - page read opcode 52h, 24 address bits, 32 dummy bits
// - read address: 3 reserved, 12 page bits, 9 byte bits
// - after dummies one output bit per further clock
// - page read leaves both buffers untouched
// - page read wraps to byte 0 of the same page
// - chip select rise ends a read and floats the output
// - buffer read opcodes 54h and 56h select buffer 1 or 2
// - buffer read: 15 dummy, 9 offset, 8 dummy bits before data
// - buffer read wraps to byte 0 of the same buffer
// - transfer opcodes 53h/55h, 3 reserved, 12 page, 9 dummy bits
// - transfer starts only at the chip select rise
// - status stays readable during transfer and shows completion
// - compare opcodes 60h/61h, same address layout as transfer
// - compare checks all 264 page bytes against the buffer
// - status shows busy throughout a compare
// - compare end writes its outcome into status bit 6
// - status opcode 57h, eight bits msb first, repeating
// - status bit 7 is 1 when idle, 0 when busy
// - status bit 6 is 0 on match, 1 on any mismatch
// - transfer keeps the device busy until done
module sfr_flash_read
  import sfr_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic i_cs_n,
  input wire logic i_sck,
  input wire logic i_si,
  input wire logic i_load_we,
  input wire logic [20:0] i_load_addr,
  input wire logic [7:0] i_load_data,
  output logic o_so,
  output logic o_so_oe
);

  logic [7:0] arr_mem [0:SFR_ARR_BYTES-1];
  logic [7:0] buf1_mem [0:SFR_PAGE_BYTES-1];
  logic [7:0] buf2_mem [0:SFR_PAGE_BYTES-1];

  //////////////////////////////////////////////////////////////////////////

  function automatic logic [20:0] flat_idx(input logic [11:0] pg,
                                           input logic [8:0] by);
    logic [20:0] base;
    base = {9'h000, pg} * SFR_ARR_AW'(SFR_PAGE_BYTES);
    flat_idx = base + {12'h000, by};
  endfunction

  function automatic logic [8:0] wrap_ptr(input logic [8:0] p);
    wrap_ptr = (p >= SFR_LAST_BYTE) ? 9'h000 : p + 9'h001;
  endfunction

  function automatic logic [8:0] clamp_ptr(input logic [8:0] p);
    clamp_ptr = (p > SFR_LAST_BYTE) ? 9'h000 : p;
  endfunction

  function automatic logic is_xfer(input logic [7:0] op);
    is_xfer = (op == SFR_OP_XFER1) || (op == SFR_OP_XFER2);
  endfunction

  function automatic logic is_cmp(input logic [7:0] op);
    is_cmp = (op == SFR_OP_CMP1) || (op == SFR_OP_CMP2);
  endfunction

  function automatic logic is_bufrd(input logic [7:0] op);
    is_bufrd = (op == SFR_OP_BUF1_RD) || (op == SFR_OP_BUF2_RD);
  endfunction

  //////////////////////////////////////////////////////////////////////////
  // link side, serial clock domain; chip select high clears the frame

  logic [6:0] cnt_q;
  logic [23:0] sr_q;
  logic data_q;
  logic [7:0] op_q;
  logic [23:0] addr_q;
  logic cmd_tgl_q;
  logic [1:0] stat_s1_q;
  logic [1:0] stat_s2_q;
  logic [7:0] op_now;
  logic [7:0] stat_byte;
  // core flags, declared here as the status synchroniser reads them first
  logic idle_w;
  logic cmp_q;

  assign op_now = {sr_q[6:0], i_si};
  assign stat_byte = {stat_s2_q, SFR_DENSITY_CODE, SFR_STAT_RSVD};

  always_ff @(posedge i_sck or posedge i_cs_n) begin
    if (i_cs_n) begin
      cnt_q <= 7'h00;
      sr_q <= 24'h00_0000;
    end else begin
      cnt_q <= (cnt_q == SFR_CNT_MAX) ? cnt_q : cnt_q + 7'h01;
      sr_q <= {sr_q[22:0], i_si};
    end
  end

  // data phase opens at the edge taking the last lead-in bit
  always_ff @(posedge i_sck or posedge i_cs_n) begin
    if (i_cs_n) begin
      data_q <= 1'b0;
    end else if (!data_q) begin
      if (cnt_q == SFR_CNT_OP_END && op_now == SFR_OP_STATUS) begin
        data_q <= 1'b1;
      end else if (cnt_q == SFR_CNT_PG_DATA && op_q == SFR_OP_PAGE_RD) begin
        data_q <= 1'b1;
      end else if (cnt_q == SFR_CNT_BUF_DATA && is_bufrd(op_q)) begin
        data_q <= 1'b1;
      end
    end
  end

  // command fields survive chip select rise so the core can take them
  always_ff @(posedge i_sck or negedge i_nrst) begin
    if (!i_nrst) begin
      op_q <= 8'h00;
      addr_q <= 24'h00_0000;
      cmd_tgl_q <= 1'b0;
    end else begin
      if (cnt_q == SFR_CNT_OP_END) begin
        op_q <= op_now;
      end
      if (cnt_q == SFR_CNT_ADDR_END) begin
        addr_q <= {sr_q[22:0], i_si};
        if (is_xfer(op_q) || is_cmp(op_q)) begin
          cmd_tgl_q <= ~cmd_tgl_q;
        end
      end
    end
  end

  // status only refreshes while the clock runs
  always_ff @(posedge i_sck or negedge i_nrst) begin
    if (!i_nrst) begin
      stat_s1_q <= 2'h0;
      stat_s2_q <= 2'h0;
    end else begin
      stat_s1_q <= {idle_w, cmp_q};
      stat_s2_q <= stat_s1_q;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // output shifter on the falling edge, valid for both clock modes

  logic [8:0] ptr_q;
  logic [2:0] bidx_q;
  logic run_q;
  logic so_q;
  logic so_oe_q;
  logic [8:0] cur_ptr;
  logic [7:0] rd_byte;

  // offsets past the end start at byte 0
  assign cur_ptr = run_q ? ptr_q : clamp_ptr(addr_q[SFR_BYTE_MSB:0]);

  always_comb begin
    rd_byte = stat_byte;
    if (op_q == SFR_OP_PAGE_RD) begin
      rd_byte = arr_mem[flat_idx(addr_q[SFR_PG_MSB:SFR_PG_LSB], cur_ptr)];
    end else if (op_q == SFR_OP_BUF1_RD) begin
      rd_byte = buf1_mem[cur_ptr];
    end else if (op_q == SFR_OP_BUF2_RD) begin
      rd_byte = buf2_mem[cur_ptr];
    end
  end

  always_ff @(negedge i_sck or posedge i_cs_n) begin
    if (i_cs_n) begin
      so_q <= 1'b0;
      so_oe_q <= 1'b0;
      ptr_q <= 9'h000;
      bidx_q <= 3'h7;
      run_q <= 1'b0;
    end else if (data_q) begin
      so_q <= rd_byte[bidx_q];
      so_oe_q <= 1'b1;
      run_q <= 1'b1;
      bidx_q <= bidx_q - 3'h1;
      if (bidx_q == 3'h0) begin
        ptr_q <= wrap_ptr(cur_ptr);
      end else begin
        ptr_q <= cur_ptr;
      end
    end
  end

  assign o_so = so_q;
  assign o_so_oe = so_oe_q;

  //////////////////////////////////////////////////////////////////////////
  // core side, system clock domain

  logic cs_s1_q;
  logic cs_s2_q;
  logic cs_s3_q;
  logic tgl_s1_q;
  logic tgl_s2_q;
  logic seen_q;
  logic cs_rise;
  logic start_go;

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      cs_s1_q <= 1'b1;
      cs_s2_q <= 1'b1;
      cs_s3_q <= 1'b1;
      tgl_s1_q <= 1'b0;
      tgl_s2_q <= 1'b0;
    end else begin
      cs_s1_q <= i_cs_n;
      cs_s2_q <= cs_s1_q;
      cs_s3_q <= cs_s2_q;
      tgl_s1_q <= cmd_tgl_q;
      tgl_s2_q <= tgl_s1_q;
    end
  end

  // a toggle is only seen once, so a later short frame cannot replay it
  assign cs_rise = cs_s2_q && !cs_s3_q;
  assign start_go = cs_rise && (tgl_s2_q != seen_q) && idle_w;

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      seen_q <= 1'b0;
    end else if (cs_rise) begin
      seen_q <= tgl_s2_q;
    end
  end

  sfr_state_t st_q;
  logic [8:0] idx_q;
  logic mism_q;
  logic sel2_q;
  logic [11:0] page_q;
  logic [7:0] arr_byte;
  logic [7:0] buf_byte;
  logic diff;

  assign idle_w = st_q[SFR_IDLE_IDX];
  assign arr_byte = arr_mem[flat_idx(page_q, idx_q)];
  assign buf_byte = sel2_q ? buf2_mem[idx_q] : buf1_mem[idx_q];
  assign diff = arr_byte != buf_byte;

  // one byte per clock; fields sampled while the link clock is quiet
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      st_q <= SFR_ST_IDLE;
      idx_q <= 9'h000;
      mism_q <= 1'b0;
      cmp_q <= 1'b0;
      sel2_q <= 1'b0;
      page_q <= 12'h000;
    end else begin
      unique case (st_q)
        SFR_ST_IDLE: begin
          if (start_go) begin
            st_q <= is_xfer(op_q) ? SFR_ST_XFER : SFR_ST_CMP;
            sel2_q <= (op_q == SFR_OP_XFER2) || (op_q == SFR_OP_CMP2);
            page_q <= addr_q[SFR_PG_MSB:SFR_PG_LSB];
            idx_q <= 9'h000;
            mism_q <= 1'b0;
          end
        end
        SFR_ST_XFER: begin
          idx_q <= idx_q + 9'h001;
          if (idx_q == SFR_LAST_BYTE) begin
            st_q <= SFR_ST_IDLE;
          end
        end
        SFR_ST_CMP: begin
          idx_q <= idx_q + 9'h001;
          mism_q <= mism_q || diff;
          if (idx_q == SFR_LAST_BYTE) begin
            st_q <= SFR_ST_IDLE;
            cmp_q <= mism_q || diff;
          end
        end
        default: begin
          st_q <= SFR_ST_IDLE;
        end
      endcase
    end
  end

  // only a transfer writes a buffer
  always_ff @(posedge i_clk) begin
    if (st_q == SFR_ST_XFER) begin
      if (sel2_q) begin
        buf2_mem[idx_q] <= arr_byte;
      end else begin
        buf1_mem[idx_q] <= arr_byte;
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_load_we) begin
      arr_mem[i_load_addr] <= i_load_data;
    end
  end

  //////////////////////////////////////////////////////////////////////////

  xfer_start_a: assert property (
    @(posedge i_clk) disable iff (!i_nrst)
    start_go && is_xfer(op_q) |=> st_q == SFR_ST_XFER)
    else $error("transfer did not start at select rise");

  busy_len_a: assert property (
    @(posedge i_clk) disable iff (!i_nrst)
    $fell(idle_w) |-> ##263 !idle_w ##1 idle_w)
    else $error("busy period not 264 cycles");

  cmp_flag_a: assert property (
    @(posedge i_clk) disable iff (!i_nrst)
    (st_q == SFR_ST_CMP && idx_q == SFR_LAST_BYTE)
    |=> idle_w && (cmp_q == $past(mism_q || diff)))
    else $error("compare flag wrong at end");

  partial_a: assert property (
    @(posedge i_clk) disable iff (!i_nrst)
    cs_rise && (tgl_s2_q == seen_q) && idle_w |=> idle_w)
    else $error("operation started without full command");

  page_rd_a: assert property (
    @(posedge i_clk) disable iff (!i_nrst)
    cs_rise && op_q == SFR_OP_PAGE_RD && idle_w |=> idle_w)
    else $error("page read started the core");

  oe_quiet_a: assert property (
    @(posedge i_clk) disable iff (!i_nrst)
    cs_s2_q |-> !so_oe_q)
    else $error("output driven while deselected");

  lead_quiet_a: assert property (
    @(posedge i_sck) disable iff (i_cs_n)
    (cnt_q > SFR_CNT_OP_END) &&
    ((op_q == SFR_OP_PAGE_RD && cnt_q <= SFR_CNT_PG_DATA) ||
     (is_bufrd(op_q) && cnt_q <= SFR_CNT_BUF_DATA)) |-> !so_oe_q)
    else $error("output before lead-in complete");

  wrap_a: assert property (
    @(negedge i_sck) disable iff (i_cs_n)
    data_q && run_q && ptr_q == SFR_LAST_BYTE && bidx_q == 3'h0
    |=> ptr_q == 9'h000)
    else $error("read pointer did not wrap");

  msb_a: assert property (
    @(negedge i_sck) disable iff (i_cs_n)
    $rose(so_oe_q) |-> bidx_q == 3'h6 && !$past(run_q))
    else $error("first bit out not msb");

  stat_out_a: assert property (
    @(negedge i_sck) disable iff (i_cs_n)
    data_q && op_q == SFR_OP_STATUS |=> o_so == $past(stat_byte[bidx_q]))
    else $error("status bit out wrong");

endmodule
`default_nettype wire

/* sfr_flash_read_unused_guard.sv */
`timescale 1ns/1ns
`default_nettype none
`default_nettype wire

/* sfr_host.sv */
// host side spi master model driving the flash front end link
// assumes the bench calls frame(); one bit every 32 ns, sck idle between
`timescale 1ns/1ns
`default_nettype none
module sfr_host (
  output logic o_cs_n,
  output logic o_sck,
  output logic o_si,
  input wire logic i_so,
  input wire logic i_so_oe
);
  logic [31:0] rd_q;
  logic oe_q;

  initial begin
    o_cs_n = 1'b0;
    o_sck = 1'b0;
    o_si = 1'b0;
    // a clean select rise clears the link flops before the first frame
    #2;
    o_cs_n = 1'b1;
  end

  //////////////////////////////////////////////////////////////////////////
  // one framed instruction: nb lead-in bits out, nr bits read back
  task automatic frame(input logic [63:0] bits, input int nb, input int nr,
                       input bit m3);
    int i;
    rd_q = 32'h0;
    oe_q = 1'b1;
    o_sck = m3; // idle level picks mode 0 or 3
    #16 o_cs_n = 1'b0;
    #16 o_sck = 1'b0;
    for (i = 0; i < nb + nr; i++) begin
      o_si = (i < nb) ? bits[nb-1-i] : ~o_si;
      #16 o_sck = 1'b1;
      if (i >= nb) begin
        rd_q = {rd_q[30:0], i_so};
        oe_q = oe_q & i_so_oe;
      end
      #16;
      // mode 3 ends high so no stray edge before the rise of select
      if (!m3 || i < nb + nr - 1) o_sck = 1'b0;
    end
    #16 o_cs_n = 1'b1;
    o_si = ~o_si; // a released line must not look held
    #48;
  endtask
endmodule
`default_nettype wire

/* sfr_pkg.sv */
// constants and types for the serial flash read-side command front end
// assumes one compilation unit holds this package ahead of the design
`default_nettype none
package sfr_pkg;
  localparam int unsigned SFR_PAGES = 4096;
  localparam int unsigned SFR_PAGE_BYTES = 264;
  localparam int unsigned SFR_ARR_BYTES = SFR_PAGES * SFR_PAGE_BYTES;
  localparam int unsigned SFR_ARR_AW = 21;
  localparam logic [8:0] SFR_LAST_BYTE = 9'h107;

  localparam logic [7:0] SFR_OP_PAGE_RD = 8'h52;
  localparam logic [7:0] SFR_OP_XFER1 = 8'h53;
  localparam logic [7:0] SFR_OP_BUF1_RD = 8'h54;
  localparam logic [7:0] SFR_OP_XFER2 = 8'h55;
  localparam logic [7:0] SFR_OP_BUF2_RD = 8'h56;
  localparam logic [7:0] SFR_OP_STATUS = 8'h57;
  localparam logic [7:0] SFR_OP_CMP1 = 8'h60;
  localparam logic [7:0] SFR_OP_CMP2 = 8'h61;

  // bit counts already received at the edge that takes a field's last bit; SFR_CNT_MAX is where the count saturates
  localparam logic [6:0] SFR_CNT_OP_END = 7'h07;
  localparam logic [6:0] SFR_CNT_ADDR_END = 7'h1f;
  localparam logic [6:0] SFR_CNT_BUF_DATA = 7'h27;
  localparam logic [6:0] SFR_CNT_PG_DATA = 7'h3f;
  localparam logic [6:0] SFR_CNT_MAX = 7'h7f;

  localparam int unsigned SFR_PG_MSB = 20;
  localparam int unsigned SFR_PG_LSB = 9;
  localparam int unsigned SFR_BYTE_MSB = 8;
  localparam int unsigned SFR_IDLE_IDX = 0;

  // density code value is arbitrary
  localparam logic [2:0] SFR_DENSITY_CODE = 3'h0;
  localparam logic [2:0] SFR_STAT_RSVD = 3'h0;

  typedef enum logic [2:0] {
    SFR_ST_IDLE = 3'b001,
    SFR_ST_XFER = 3'b010,
    SFR_ST_CMP = 3'b100
  } sfr_state_t;
endpackage
`default_nettype wire

/* testbench.sv */
// self-checking bench for the serial flash read-side front end
// assumes sfr_pkg is compiled first; host model drives the link
`timescale 1ns/1ns
`default_nettype none
module testbench
  import sfr_pkg::*;
;
  logic clk, nrst, we;
  logic [20:0] la;
  logic [7:0] ld;
  wire logic cs_n, sck, si, so, so_oe;
  int fails = 0;
  int cmp_count = 0;
  logic [7:0] st;
  localparam logic [7:0] IDLE_ST = {2'b10, SFR_DENSITY_CODE, 3'h0};

  sfr_flash_read dut_u (.i_clk(clk), .i_nrst(nrst), .i_cs_n(cs_n),
    .i_sck(sck), .i_si(si), .i_load_we(we), .i_load_addr(la),
    .i_load_data(ld), .o_so(so), .o_so_oe(so_oe));
  sfr_host host_u (.o_cs_n(cs_n), .o_sck(sck), .o_si(si), .i_so(so),
    .i_so_oe(so_oe));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  //////////////////////////////////////////////////////////////////////////
  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask

  function automatic logic [7:0] pat(input int pg, input int b);
    return 8'(b ^ (pg << 4));
  endfunction

  task automatic load_page(input int pg);
    int b;
    for (b = 0; b < 264; b++) begin
      @(posedge clk);
      we <= 1'b1;
      la <= 21'(pg * 264 + b);
      ld <= pat(pg, b);
    end
    @(posedge clk);
    we <= 1'b0;
  endtask

  // status byte read twice; the second copy is the fresh one
  task automatic stat;
    host_u.frame({56'h0, SFR_OP_STATUS}, 8, 16, 1'b1);
  endtask

  //////////////////////////////////////////////////////////////////////////
  task automatic t_status;
    stat();
    chk(32'(host_u.rd_q[15:0]), {16'h0, IDLE_ST, IDLE_ST});
    $display("test status done");
  endtask

  task automatic t_busy(input logic [7:0] op, input logic [11:0] pg);
    int n;
    host_u.frame({32'h0, op, 3'h0, pg, 9'h0}, 32, 0, 1'b0);
    stat();
    chk(32'(host_u.rd_q[7]), 32'h0);
    n = 0;
    while (host_u.rd_q[7] !== 1'b1 && n < 20) begin
      stat();
      n++;
    end
    chk(32'(host_u.rd_q[7]), 32'h1);
    st = host_u.rd_q[7:0];
    $display("test busy op %h done", op);
  endtask

  task automatic t_page_rd(input logic [11:0] pg);
    // reserved bits set to ones, start two bytes before the page end
    host_u.frame({SFR_OP_PAGE_RD, 3'h7, pg, 9'h106, 32'h0}, 64, 24, 1'b0);
    chk(32'(host_u.rd_q[23:0]),
        {8'h0, pat(pg, 262), pat(pg, 263), pat(pg, 0)});
    chk(32'(host_u.oe_q), 32'h1);
    chk(32'(so_oe), 32'h0);
    $display("test page read done");
  endtask

  task automatic t_buf_rd(input logic [7:0] op, input int pg);
    host_u.frame({24'h0, op, 15'h0, 9'h107, 8'h0}, 40, 16, 1'b1);
    chk(32'(host_u.rd_q[15:0]),
        {16'h0, pat(pg, 263), pat(pg, 0)});
    chk(32'(so_oe), 32'h0);
    $display("test buffer read %h done", op);
  endtask

  task automatic t_partial;
    // stale address names page 5, so a wrong start would refill buffer 2
    host_u.frame({40'h0, SFR_OP_XFER2, 16'h0012}, 24, 0, 1'b0);
    stat();
    chk(32'(host_u.rd_q[7:0]), 32'(IDLE_ST | st));
    t_buf_rd(SFR_OP_BUF2_RD, 9);
    $display("test partial done");
  endtask

  //////////////////////////////////////////////////////////////////////////
  initial begin
    // late fall so every reset process sees an edge
    nrst = 1'b1;
    #1;
    nrst = 1'b0;
    we = 1'b0;
    la = 21'h0;
    ld = 8'h0;
    repeat (3) @(posedge clk);
    nrst <= 1'b1;
    load_page(5);
    load_page(9);
    t_status();
    t_busy(SFR_OP_XFER1, 12'h005);
    t_busy(SFR_OP_XFER2, 12'h009);
    t_page_rd(12'h005);
    t_buf_rd(SFR_OP_BUF1_RD, 5);
    t_buf_rd(SFR_OP_BUF2_RD, 9);
    t_busy(SFR_OP_CMP1, 12'h005);
    chk(32'(st[6]), 32'h0);
    t_busy(SFR_OP_CMP2, 12'h005);
    chk(32'(st[6]), 32'h1);
    t_partial();
    report_and_stop();
  end

  // whole run needs about 40 us; five times that means a hang
  initial begin
    #200000;
    fails++;
    report_and_stop();
  end
endmodule
`default_nettype wire
